// [include/timer_irq_defs.vh]
// Purpose: constants for the timer interrupt flag block
// Assumes: apb with 32-bit data, one word per register
// Notes:   offsets are byte addresses
`ifndef TIMER_IRQ_DEFS_VH
`define TIMER_IRQ_DEFS_VH

`define TIRQ_ADDR_W          8
`define TIRQ_OFS_CONTROL     8'h00
`define TIRQ_OFS_CLEAR       8'h04
`define TIRQ_OFS_MODULE      8'h08
`define TIRQ_OFS_STATUS      8'h0C
`define TIRQ_OFS_MASK        8'h10
`define TIRQ_CONTROL_RESET   8'h00
`define TIRQ_PND_RESET       4'h0
`define TIRQ_EN_RESET        4'h0
`define TIRQ_MODULE_RESET    1'b0
`define TIRQ_STATUS_RESET    2'h0
`define TIRQ_MASK_RESET      2'h0
`define TIRQ_CLEAR_READ      8'hFF
`define TIRQ_EN_LSB          4
`define TIRQ_PND_LSB         0
`define TIRQ_NSRC            4
`define TIRQ_MODULE_EN_BIT   0
`define TIRQ_STATUS_SET_BIT  0
`define TIRQ_STATUS_FLAG_BIT 1

`endif

// [src/timer_interrupt_flags.v]
// Purpose: pending and enable flags of four timer interrupt sources, apb register access
// Assumes: pclk 100 MHz; src_event from timer core logic on pclk, one bit per source
// Notes:   bus answers with zero wait states; unmapped reads give zero, pslverr low
//
// Overview of operation
// [RQ1] reset clears the whole 8-bit control register to zero
// [RQ2] enables in bits 7..4, pending flags in bits 3..0, order D C B A
// [RQ3] timer core event sets the matching pending flag
// [RQ4] software writing one to a pending bit sets it
// [RQ5] software writing zero to a pending bit is ignored
// [RQ6] a source requests interrupt only while its enable bit is one
// [RQ7] clear register is 8 bits, write-only, reads back as all ones
// [RQ8] clear bits 0..3 clear pending A..D; bits 7..4 reserved
// [RQ9] writing zero to a clear bit leaves the pending flag alone
// [RQ10] software must not update clear register by read-modify-write
// [RQ11] timer disabled: pending flags held cleared and writes rejected
// [RQ12] timer request is OR of pending AND enable over sources
// [RQ13] hardware set beats a clear-register write in the same cycle
//
// Implementation choices: the APB register port and the placing of the registers.
`timescale 1ns/100ps
`include "timer_irq_defs.vh"

module timer_interrupt_flags (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output wire        pslverr,
  output reg  [31:0] prdata,
  input  wire [3:0]  src_event,
  output wire        timer_module_enable,
  output wire        timer_irq,
  output wire        sys_irq
);

  localparam [2:0] SEL_NONE    = 3'h0;
  localparam [2:0] SEL_CONTROL = 3'h1;
  localparam [2:0] SEL_CLEAR   = 3'h2;
  localparam [2:0] SEL_MODULE  = 3'h3;
  localparam [2:0] SEL_STATUS  = 3'h4;
  localparam [2:0] SEL_MASK    = 3'h5;

  reg  [3:0]  pending_ff;
  reg  [3:0]  enable_ff;
  reg         module_en_ff;
  reg  [1:0]  status_ff;
  reg  [1:0]  mask_ff;
  reg         irq_prev_ff;
  reg  [3:0]  nxt_pending;
  reg  [3:0]  nxt_enable;
  reg         nxt_module_en;
  reg  [1:0]  nxt_status;
  reg  [1:0]  nxt_mask;
  reg         nxt_irq_prev;
  reg  [31:0] nxt_prdata;
  wire [2:0]  reg_sel;
  wire        wr_acc;
  wire        rd_acc;
  wire        rd_setup;
  wire        wr_control;
  wire        wr_clear;
  wire        wr_module;
  wire        wr_mask;
  wire        rd_status;
  wire        flags_run;
  wire        irq_rise;
  wire        hw_event_any;
  wire [3:0]  sw_set;
  wire [3:0]  sw_clr;
  wire [3:0]  hw_set;
  wire [3:0]  irq_active;
  wire        src_a_pending;
  wire        src_b_pending;
  wire        src_c_pending;
  wire        src_d_pending;
  wire        src_a_irq_enable;
  wire        src_b_irq_enable;
  wire        src_c_irq_enable;
  wire        src_d_irq_enable;
  wire        src_a_clear;
  wire        src_b_clear;
  wire        src_c_clear;
  wire        src_d_clear;

  // map a byte address onto one register of the block
  function [2:0] reg_decode;
    input [7:0] a;
    begin
      case (a)
        `TIRQ_OFS_CONTROL: reg_decode = SEL_CONTROL;
        `TIRQ_OFS_CLEAR:   reg_decode = SEL_CLEAR;
        `TIRQ_OFS_MODULE:  reg_decode = SEL_MODULE;
        `TIRQ_OFS_STATUS:  reg_decode = SEL_STATUS;
        `TIRQ_OFS_MASK:    reg_decode = SEL_MASK;
        default:           reg_decode = SEL_NONE;
      endcase
    end
  endfunction

  // one pending flag: clear first, then any set, held low while the timer is off
  function next_flag;
    input cur;
    input set_sw;
    input set_hw;
    input clr;
    input run;
    begin
      if (!run) begin
        next_flag = 1'b0;
      end else begin
        next_flag = (cur & ~clr) | set_sw | set_hw;
      end
    end
  endfunction

  // one sticky status bit: a read clears only what it returned, a new event wins
  function next_sticky;
    input cur;
    input set;
    input clr;
    begin
      next_sticky = (cur & ~clr) | set;
    end
  endfunction

  // 8-bit register value zero-extended onto the bus word
  function [31:0] bus_word;
    input [7:0] b;
    begin
      bus_word = {24'h00_0000, b};
    end
  endfunction

  assign reg_sel  = reg_decode(paddr);
  assign pready   = 1'b1;
  assign pslverr  = 1'b0;
  assign wr_acc   = psel & penable & pwrite;
  assign rd_acc   = psel & penable & ~pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;

  assign wr_control = wr_acc & (reg_sel == SEL_CONTROL);
  assign wr_clear   = wr_acc & (reg_sel == SEL_CLEAR);
  assign wr_module  = wr_acc & (reg_sel == SEL_MODULE);
  assign wr_mask    = wr_acc & (reg_sel == SEL_MASK);
  assign rd_status  = rd_acc & (reg_sel == SEL_STATUS);

  assign src_a_pending    = pending_ff[0];
  assign src_b_pending    = pending_ff[1];
  assign src_c_pending    = pending_ff[2];
  assign src_d_pending    = pending_ff[3];
  assign src_a_irq_enable = enable_ff[0];
  assign src_b_irq_enable = enable_ff[1];
  assign src_c_irq_enable = enable_ff[2];
  assign src_d_irq_enable = enable_ff[3];
  assign timer_module_enable = module_en_ff;

  // reserved bits 7..4 of the clear register are not looked at
  assign src_a_clear = wr_clear & pwdata[`TIRQ_PND_LSB + 0];                // [RQ8] [RQ9]
  assign src_b_clear = wr_clear & pwdata[`TIRQ_PND_LSB + 1];                // [RQ8] [RQ9]
  assign src_c_clear = wr_clear & pwdata[`TIRQ_PND_LSB + 2];                // [RQ8] [RQ9]
  assign src_d_clear = wr_clear & pwdata[`TIRQ_PND_LSB + 3];                // [RQ8] [RQ9]

  // zeros in the pending field of a control write are don't-care
  assign sw_set = wr_control ? pwdata[`TIRQ_PND_LSB +: `TIRQ_NSRC] : 4'h0;  // [RQ4] [RQ5]
  assign sw_clr = {src_d_clear, src_c_clear, src_b_clear, src_a_clear};     // [RQ8]
  assign hw_set = src_event;                                                 // [RQ3]

  always @* begin
    nxt_module_en = module_en_ff;
    if (wr_module) begin
      nxt_module_en = pwdata[`TIRQ_MODULE_EN_BIT];
    end
  end

  // switching off clears the flags at that same edge, so no request outlives the enable
  assign flags_run = module_en_ff & nxt_module_en;                           // [RQ11]

  always @* begin
    nxt_pending[0] = next_flag(pending_ff[0], sw_set[0], hw_set[0], sw_clr[0], flags_run); // [RQ11] [RQ13]
    nxt_pending[1] = next_flag(pending_ff[1], sw_set[1], hw_set[1], sw_clr[1], flags_run); // [RQ11] [RQ13]
    nxt_pending[2] = next_flag(pending_ff[2], sw_set[2], hw_set[2], sw_clr[2], flags_run); // [RQ11] [RQ13]
    nxt_pending[3] = next_flag(pending_ff[3], sw_set[3], hw_set[3], sw_clr[3], flags_run); // [RQ11] [RQ13]
  end

  always @* begin
    nxt_enable = enable_ff;
    if (wr_control) begin
      nxt_enable = pwdata[`TIRQ_EN_LSB +: `TIRQ_NSRC];                        // [RQ2]
    end
  end

  // request: pending gated by enable
  assign irq_active = pending_ff & enable_ff;                                // [RQ6]
  assign timer_irq  = |irq_active;                                           // [RQ12]

  // sticky status: bit0 rising edge of request, bit1 any new hardware event while the timer is on
  assign irq_rise     = timer_irq & ~irq_prev_ff;
  assign hw_event_any = module_en_ff & (|src_event);

  // prdata still holds the value that the status read returns during its access phase
  always @* begin
    nxt_irq_prev = timer_irq;
    nxt_status[`TIRQ_STATUS_SET_BIT]  = next_sticky(status_ff[`TIRQ_STATUS_SET_BIT], irq_rise,
                                                    rd_status & prdata[`TIRQ_STATUS_SET_BIT]);
    nxt_status[`TIRQ_STATUS_FLAG_BIT] = next_sticky(status_ff[`TIRQ_STATUS_FLAG_BIT], hw_event_any,
                                                    rd_status & prdata[`TIRQ_STATUS_FLAG_BIT]);
  end

  always @* begin
    nxt_mask = mask_ff;
    if (wr_mask) begin
      nxt_mask = pwdata[`TIRQ_STATUS_FLAG_BIT:`TIRQ_STATUS_SET_BIT];
    end
  end

  assign sys_irq = |(status_ff & mask_ff);

  always @* begin
    nxt_prdata = 32'h0000_0000;
    case (reg_sel)
      SEL_CONTROL: begin
        nxt_prdata = bus_word({enable_ff, pending_ff});                      // [RQ2]
      end
      SEL_CLEAR: begin
        nxt_prdata = bus_word(`TIRQ_CLEAR_READ);                             // [RQ7]
      end
      SEL_MODULE: begin
        nxt_prdata = bus_word({7'h00, module_en_ff});
      end
      SEL_STATUS: begin
        nxt_prdata = bus_word({6'h00, status_ff});
      end
      SEL_MASK: begin
        nxt_prdata = bus_word({6'h00, mask_ff});
      end
      default: begin
        nxt_prdata = 32'h0000_0000;
      end
    endcase
  end

  // pending and enable flags together form the control register
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pending_ff <= `TIRQ_PND_RESET;                                         // [RQ1]
      enable_ff  <= `TIRQ_EN_RESET;                                          // [RQ1]
    end else begin
      pending_ff <= nxt_pending;
      enable_ff  <= nxt_enable;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      module_en_ff <= `TIRQ_MODULE_RESET;
    end else begin
      module_en_ff <= nxt_module_en;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_ff   <= `TIRQ_STATUS_RESET;
      irq_prev_ff <= 1'b0;
    end else begin
      status_ff   <= nxt_status;
      irq_prev_ff <= nxt_irq_prev;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_ff <= `TIRQ_MASK_RESET;
    end else begin
      mask_ff <= nxt_mask;
    end
  end

  // read data registered in setup so it stands in the access phase
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata <= nxt_prdata;
    end
  end

endmodule

// [test/tb_timer_interrupt_flags.sv]
// Purpose: random and corner tests of timer_interrupt_flags
// Assumes: zero-wait apb, offsets from timer_irq_defs.vh
// Notes:   model keeps pending, enable and module enable
`timescale 1ns/100ps
`include "timer_irq_defs.vh"
module tb_timer_interrupt_flags;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, md = 0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdat, seed = 32'h0BBC;
  logic [3:0]  src_event = 4'h0, pnd = 4'h0, en = 4'h0;
  logic        pready, pslverr, mod_en, timer_irq, sys_irq;
  int          n_fail = 0, total_checks = 0, cyc = 0;
  timer_interrupt_flags i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata), .src_event(src_event),
    .timer_module_enable(mod_en), .timer_irq(timer_irq), .sys_irq(sys_irq));
  always #5 pclk = ~pclk;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction
  function automatic logic exp_irq(input logic [3:0] p, input logic [3:0] e);
    return |(p & e);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    {psel, penable} <= 2'b00;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    acc(1'b1, a, d);
    if (a == `TIRQ_OFS_CONTROL) en = d[7:4];
    if (a == `TIRQ_OFS_CONTROL && md) pnd |= d[3:0];
    if (a == `TIRQ_OFS_CLEAR) pnd &= ~d[3:0];
    if (a == `TIRQ_OFS_MODULE) md = d[0];
    if (!md) pnd = 4'h0;
  endtask
  task automatic ev(input logic [3:0] v);
    @(posedge pclk);
    src_event <= v;
    @(posedge pclk);
    src_event <= 4'h0;
    if (md) pnd |= v;
  endtask
  task automatic cmp_ctrl;
    acc(1'b0, `TIRQ_OFS_CONTROL, 32'h0);
    @(negedge pclk);
    chk(rdat, {24'h0, en, pnd});
    chk(timer_irq, exp_irq(pnd, en));
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      give_verdict;
    end
  end
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    cmp_ctrl();
    acc(1'b0, `TIRQ_OFS_CLEAR, 32'h0);
    chk(rdat, 32'hFF);
    acc(1'b0, 8'h40, 32'h0);
    chk(rdat, 32'h0);
    wr(`TIRQ_OFS_CONTROL, 32'hFF);
    ev(4'hF);
    cmp_ctrl();
    wr(`TIRQ_OFS_MODULE, 32'h1);
    repeat (200) begin
      seed = xs(seed);
      wr(seed[9:8] == 2'b00 ? `TIRQ_OFS_CLEAR : `TIRQ_OFS_CONTROL, seed);
      ev(seed[23:20]);
      cmp_ctrl();
    end
    wr(`TIRQ_OFS_CONTROL, 32'hF1);
    fork
      wr(`TIRQ_OFS_CLEAR, 32'hF);
      begin
        @(posedge pclk);
        ev(4'hF);
      end
    join
    pnd = 4'hF;
    wr(`TIRQ_OFS_CONTROL, 32'hF0);
    wr(`TIRQ_OFS_CLEAR, 32'hF0);
    cmp_ctrl();
    wr(`TIRQ_OFS_MASK, 32'h2);
    acc(1'b0, `TIRQ_OFS_STATUS, 32'h0);
    ev(4'h2);
    @(negedge pclk);
    chk(sys_irq, 1'b1);
    acc(1'b0, `TIRQ_OFS_STATUS, 32'h0);
    @(negedge pclk);
    chk({rdat[1], sys_irq}, 2'b10);
    wr(`TIRQ_OFS_MASK, 32'h0);
    ev(4'h2);
    @(negedge pclk);
    chk(sys_irq, 1'b0);
    wr(`TIRQ_OFS_CLEAR, 32'hF);
    cmp_ctrl();
    give_verdict;
  end
endmodule

// [test/timer_interrupt_flags_assertions.sv]
// Purpose: port checks of timer_interrupt_flags
// Assumes: zero-wait apb, clear register at 8'h04
// Notes:   pending flags are seen through timer_irq
`timescale 1ns/100ps
module tirq_chk (
  input logic        pclk,
  input logic        presetn,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [7:0]  paddr,
  input logic [31:0] pwdata,
  input logic [31:0] prdata,
  input logic [3:0]  src_event,
  input logic        timer_module_enable,
  input logic        timer_irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire wr  = psel && penable && pwrite;
  wire ctl = wr && paddr == 8'h00;
  wire clr = wr && paddr == 8'h04;
  a_reset_quiet: assert property ($rose(presetn) |-> !timer_irq) else $error("irq after reset");
  a_clear_reads_ones: assert property (psel && !penable && !pwrite && paddr == 8'h04 |=> prdata == 32'hFF)
    else $error("clear read");
  a_disabled_quiet: assert property (!timer_module_enable |-> !timer_irq) else $error("irq while off");
  a_soft_set: assert property (ctl && pwdata[4] && pwdata[0] && timer_module_enable |=> timer_irq)
    else $error("soft set");
  a_zero_write: assert property (ctl && pwdata[7:0] == 8'hF0 && timer_irq |=> timer_irq) else $error("zero write");
  a_no_enable: assert property (ctl && pwdata[7:4] == 4'h0 |=> !timer_irq) else $error("disabled irq");
  a_hw_wins: assert property (clr && pwdata[3:0] == 4'hF && src_event == 4'hF && timer_irq |=> timer_irq)
    else $error("event lost");
  a_clear_all: assert property (clr && pwdata[3:0] == 4'hF && src_event == 4'h0 |=> !timer_irq)
    else $error("clear failed");
  a_clear_zero: assert property (clr && pwdata[3:0] == 4'h0 && timer_irq |=> timer_irq) else $error("zero clear");
  c_irq_rise: cover property ($rose(timer_irq));
  c_clash: cover property (clr && src_event != 4'h0);
  c_mod_on: cover property ($rose(timer_module_enable));
endmodule
bind timer_interrupt_flags tirq_chk i_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .src_event(src_event),
  .timer_module_enable(timer_module_enable), .timer_irq(timer_irq));
